// ==== design/asgate_pkg.sv ====
// Constants, field layout and types of the acquisition start trigger gate
package asgate_pkg;

    // Register byte offsets
    localparam logic [7:0] ASG_CTRL_OFS = 8'h00;
    localparam logic [7:0] ASG_TRIG_OFS = 8'h04;
    localparam logic [7:0] ASG_FRAMES_OFS = 8'h08;
    localparam logic [7:0] ASG_CMD_OFS = 8'h0c;
    localparam logic [7:0] ASG_STATUS_OFS = 8'h10;

    // Control register fields
    localparam int ASG_CTRL_STD_BIT = 0;
    localparam int ASG_CTRL_SEL_BIT = 1;
    localparam int ASG_CTRL_CONT_BIT = 2;
    localparam logic [2:0] ASG_CTRL_RST = 3'h0;

    // Trigger configuration fields, per selected trigger
    localparam int ASG_CFG_EN_BIT = 0;
    localparam int ASG_CFG_SRC_BIT = 1;
    localparam int ASG_CFG_FALL_BIT = 2;

    // Command register fields, write-one pulses
    localparam int ASG_CMD_SOFT_BIT = 0;
    localparam int ASG_CMD_ARM_BIT = 1;
    localparam int ASG_CMD_DISARM_BIT = 2;

    // Status register fields
    localparam int ASG_STAT_STATE_BIT = 0;
    localparam int ASG_STAT_ARMED_BIT = 1;
    localparam int ASG_STAT_BUSY_BIT = 2;
    localparam int ASG_STAT_GATE_BIT = 3;
    localparam int ASG_STAT_STYLE_BIT = 4;
    localparam int ASG_STAT_CNT_LSB = 8;

    // Frame count limits and reset value
    localparam logic [7:0] ASG_FRAMES_MIN = 8'h01;
    localparam logic [7:0] ASG_FRAMES_MAX = 8'hff;
    localparam logic [7:0] ASG_FRAMES_RST = 8'h01;

    // Encodings of selector and source
    localparam logic ASG_SEL_START = 1'b0;
    localparam logic ASG_SEL_FRAME = 1'b1;
    localparam logic ASG_SRC_SOFT = 1'b0;
    localparam logic ASG_SRC_LINE = 1'b1;

    // Settings of one trigger
    typedef struct packed {
        logic falling;
        logic origin;
        logic enable;
    } asgate_trig_cfg_t;

    localparam asgate_trig_cfg_t ASG_CFG_RST = 3'h0;

    typedef enum logic {
        ASG_WAIT_START = 1'b0,
        ASG_WAIT_FRAME = 1'b1
    } asgate_state_t;

    // Exact byte address match, all 8 address bits compared
    function automatic logic asgate_hit(input logic [7:0] addr,
                                        input logic [7:0] ofs);
        asgate_hit = (addr == ofs);
    endfunction : asgate_hit

endpackage : asgate_pkg

// ==== design/asgate_edge.sv ====
// Edge detector for the external start trigger on input line 1
`timescale 1ns/1ps
module asgate_edge
    import asgate_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic line_in,
    input wire logic falling,
    output logic edge_pulse
);

    logic prev;
    logic primed;

    // Previous level; first sample after reset only primes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
            primed <= 1'b0;
        end else begin
            prev <= line_in;
            primed <= 1'b1;
        end
    end

    // Chosen edge
    assign edge_pulse = primed &
        (falling ? (prev & ~line_in) : (~prev & line_in));

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_edge_rise_seen: assert property (
        primed && !falling && !prev && line_in |-> edge_pulse)
        else $error("rising edge not detected");
    a_edge_fall_seen: assert property (
        primed && falling && $fell(line_in) |-> edge_pulse)
        else $error("falling edge not detected");

endmodule : asgate_edge

// ==== design/asgate_top.sv ====
// Acquisition start trigger gate with APB register slave
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module asgate_top
    import asgate_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line1_in,
    input wire logic frame_trig_in,
    input wire logic frame_done_in,
    output logic frame_expose_start,
    output logic frame_soft_pulse,
    output asgate_trig_cfg_t frame_cfg,
    output logic legacy_mode
);

    logic standard_mode;
    logic trigger_target_choice;
    logic capture_run_style;
    asgate_trig_cfg_t start_cfg;
    logic [7:0] frames_per_start;
    logic host_issued_pulse;
    logic armed;
    logic frame_busy;
    asgate_state_t state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [31:0] next_rdata;
    logic wr_en;
    logic addr_ok;
    logic line_edge;
    logic gate_on;
    logic start_evt;
    logic fs_accept;
    logic style_conflict;
    logic arm_cmd;
    logic disarm_cmd;

    // APB decode; every access completes in one access cycle
    assign addr_ok = asgate_hit(paddr, ASG_CTRL_OFS) |
        asgate_hit(paddr, ASG_TRIG_OFS) |
        asgate_hit(paddr, ASG_FRAMES_OFS) |
        asgate_hit(paddr, ASG_CMD_OFS) |
        asgate_hit(paddr, ASG_STATUS_OFS);
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = psel & penable & pwrite & addr_ok & pstrb[0];

    // Control register, legacy mode after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {capture_run_style, trigger_target_choice, standard_mode}
                <= ASG_CTRL_RST;
        end else if (wr_en && asgate_hit(paddr, ASG_CTRL_OFS)) begin
            standard_mode <= pwdata[ASG_CTRL_STD_BIT];
            trigger_target_choice <= pwdata[ASG_CTRL_SEL_BIT];
            capture_run_style <= pwdata[ASG_CTRL_CONT_BIT];
        end
    end

    // Trigger settings land on the selected trigger only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_cfg <= ASG_CFG_RST;
            frame_cfg <= ASG_CFG_RST;
        end else if (wr_en && asgate_hit(paddr, ASG_TRIG_OFS)) begin
            if (trigger_target_choice == ASG_SEL_FRAME) begin
                frame_cfg.enable <= pwdata[ASG_CFG_EN_BIT];
                frame_cfg.origin <= pwdata[ASG_CFG_SRC_BIT];
                frame_cfg.falling <= pwdata[ASG_CFG_FALL_BIT];
            end else begin
                start_cfg.enable <= pwdata[ASG_CFG_EN_BIT];
                start_cfg.origin <= pwdata[ASG_CFG_SRC_BIT];
                start_cfg.falling <= pwdata[ASG_CFG_FALL_BIT];
            end
        end
    end

    // Frame count; a zero write is dropped to keep 1..255
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_per_start <= ASG_FRAMES_RST;
        end else if (wr_en && asgate_hit(paddr, ASG_FRAMES_OFS) &&
                     pwdata[7:0] >= ASG_FRAMES_MIN) begin
            frames_per_start <= pwdata[7:0];
        end
    end

    // Command pulses, one cycle after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_issued_pulse <= 1'b0;
            frame_soft_pulse <= 1'b0;
            arm_cmd <= 1'b0;
            disarm_cmd <= 1'b0;
        end else begin
            host_issued_pulse <= wr_en && asgate_hit(paddr, ASG_CMD_OFS) &&
                pwdata[ASG_CMD_SOFT_BIT] &&
                trigger_target_choice == ASG_SEL_START;
            frame_soft_pulse <= wr_en && asgate_hit(paddr, ASG_CMD_OFS) &&
                pwdata[ASG_CMD_SOFT_BIT] &&
                trigger_target_choice == ASG_SEL_FRAME;
            arm_cmd <= wr_en && asgate_hit(paddr, ASG_CMD_OFS) &&
                pwdata[ASG_CMD_ARM_BIT];
            disarm_cmd <= wr_en && asgate_hit(paddr, ASG_CMD_OFS) &&
                pwdata[ASG_CMD_DISARM_BIT];
        end
    end

    // Line 1 edge finder
    asgate_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .line_in(line1_in),
        .falling(start_cfg.falling),
        .edge_pulse(line_edge)
    );

    // Gate is live only in standard mode with enable set
    assign gate_on = standard_mode & start_cfg.enable;
    assign legacy_mode = ~standard_mode;
    // Host side misuse: gate on without continuous style
    assign style_conflict = gate_on & ~capture_run_style;

    // Start trigger from software or line 1
    assign start_evt = gate_on & ((start_cfg.origin == ASG_SRC_LINE) ?
        line_edge : host_issued_pulse);

    // Frame trigger acceptance; gate off means internal starts
    assign fs_accept = frame_trig_in & armed & ~frame_busy &
        (~gate_on | (state == ASG_WAIT_FRAME));
    assign next_count = count + 8'h01;

    // Gate state and accepted-frame count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ASG_WAIT_START;
            count <= 8'h00;
        end else if (!gate_on) begin
            state <= ASG_WAIT_START;
            count <= 8'h00;
        end else begin
            case (state)
                ASG_WAIT_START: begin
                    if (start_evt) begin
                        state <= ASG_WAIT_FRAME;
                        count <= 8'h00;
                    end
                end
                ASG_WAIT_FRAME: begin
                    // Start triggers here fall through unheeded
                    if (fs_accept) begin
                        count <= next_count;
                        if (next_count == frames_per_start) begin
                            state <= ASG_WAIT_START;
                        end
                    end
                end
                default: begin
                    state <= ASG_WAIT_START;
                end
            endcase
        end
    end

    // Arm state; disarm refuses new frames only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
        end else if (disarm_cmd) begin
            armed <= 1'b0;
        end else if (arm_cmd) begin
            armed <= 1'b1;
        end
    end

    // Exposure start and busy flag; start wins over done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_expose_start <= 1'b0;
            frame_busy <= 1'b0;
        end else begin
            frame_expose_start <= fs_accept;
            if (fs_accept) begin
                frame_busy <= 1'b1;
            end else if (frame_done_in) begin
                frame_busy <= 1'b0;
            end
        end
    end

    // Read data mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (asgate_hit(paddr, ASG_CTRL_OFS)) begin
            next_rdata[ASG_CTRL_STD_BIT] = standard_mode;
            next_rdata[ASG_CTRL_SEL_BIT] = trigger_target_choice;
            next_rdata[ASG_CTRL_CONT_BIT] = capture_run_style;
        end else if (asgate_hit(paddr, ASG_TRIG_OFS)) begin
            if (trigger_target_choice == ASG_SEL_FRAME) begin
                next_rdata[ASG_CFG_EN_BIT] = frame_cfg.enable;
                next_rdata[ASG_CFG_SRC_BIT] = frame_cfg.origin;
                next_rdata[ASG_CFG_FALL_BIT] = frame_cfg.falling;
            end else begin
                next_rdata[ASG_CFG_EN_BIT] = start_cfg.enable;
                next_rdata[ASG_CFG_SRC_BIT] = start_cfg.origin;
                next_rdata[ASG_CFG_FALL_BIT] = start_cfg.falling;
            end
        end else if (asgate_hit(paddr, ASG_FRAMES_OFS)) begin
            next_rdata[7:0] = frames_per_start;
        end else if (asgate_hit(paddr, ASG_STATUS_OFS)) begin
            next_rdata[ASG_STAT_STATE_BIT] = state;
            next_rdata[ASG_STAT_ARMED_BIT] = armed;
            next_rdata[ASG_STAT_BUSY_BIT] = frame_busy;
            next_rdata[ASG_STAT_GATE_BIT] = gate_on;
            next_rdata[ASG_STAT_STYLE_BIT] = style_conflict;
            next_rdata[ASG_STAT_CNT_LSB +: 8] = count;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= next_rdata;
        end
    end

    // Helper: control register ever written since reset
    logic ctrl_written;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_written <= 1'b0;
        end else if (wr_en && asgate_hit(paddr, ASG_CTRL_OFS)) begin
            ctrl_written <= 1'b1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_soft_start_cmd;
        wr_en && asgate_hit(paddr, ASG_CMD_OFS) &&
            pwdata[ASG_CMD_SOFT_BIT] &&
            trigger_target_choice == ASG_SEL_START;
    endsequence

    sequence s_soft_frame_cmd;
        wr_en && asgate_hit(paddr, ASG_CMD_OFS) &&
            pwdata[ASG_CMD_SOFT_BIT] &&
            trigger_target_choice == ASG_SEL_FRAME;
    endsequence

    sequence s_gate_opened;
        gate_on && state == ASG_WAIT_START && start_evt;
    endsequence

    a_legacy_no_gate: assert property (
        !standard_mode |=> state == ASG_WAIT_START && count == 8'h00)
        else $error("gate active in legacy mode");
    a_reset_legacy: assert property (
        !ctrl_written |-> !standard_mode && legacy_mode)
        else $error("not legacy after reset");
    a_discard_waiting: assert property (
        gate_on && state == ASG_WAIT_START |=> !frame_expose_start)
        else $error("frame accepted while waiting for start");
    a_start_opens: assert property (
        s_gate_opened ##1 gate_on |-> state == ASG_WAIT_FRAME)
        else $error("start trigger did not open gate");
    a_count_clears: assert property (
        s_gate_opened |=> count == 8'h00)
        else $error("count not cleared on leaving start wait");
    a_count_return: assert property (
        gate_on && state == ASG_WAIT_FRAME && fs_accept &&
        next_count == frames_per_start ##1 gate_on
        |-> state == ASG_WAIT_START)
        else $error("no return after frame count");
    a_gate_off_free: assert property (
        !gate_on && frame_trig_in && armed && !frame_busy
        |=> frame_expose_start)
        else $error("frame refused with gate off");
    a_soft_start: assert property (
        s_soft_start_cmd ##1 (gate_on && !start_cfg.origin &&
        state == ASG_WAIT_START) |-> start_evt)
        else $error("software command gave no start");
    a_line_start: assert property (
        gate_on && start_cfg.origin && line_edge |-> start_evt)
        else $error("line edge gave no start");
    a_ignore_restart: assert property (
        gate_on && state == ASG_WAIT_FRAME && start_evt && !fs_accept
        ##1 gate_on |-> state == ASG_WAIT_FRAME && $stable(count))
        else $error("start trigger disturbed frame wait");
    a_frames_range: assert property (
        frames_per_start >= ASG_FRAMES_MIN &&
        frames_per_start <= ASG_FRAMES_MAX)
        else $error("frame count out of range");
    a_target_route: assert property (
        s_soft_frame_cmd |=> frame_soft_pulse && !host_issued_pulse)
        else $error("software command misrouted");
    a_disarm_blocks: assert property (
        disarm_cmd |=> !armed ##1 !frame_expose_start)
        else $error("frame accepted after disarm");

endmodule : asgate_top

// ==== verification/asgate_ext_src.sv ====
// External trigger source and frame readout model
`timescale 1ns/1ps
module asgate_ext_src
    import asgate_pkg::*;
#(
    parameter int DONE_LAT = 6
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic line_lvl,
    input wire logic expose_start,
    output logic line1_in,
    output logic frame_trig_in,
    output logic frame_done_in
);
    int cnt;

    // Line level and frame trigger launched right after a clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line1_in <= 1'b0;
            frame_trig_in <= 1'b0;
        end else begin
            line1_in <= line_lvl;
            frame_trig_in <= fire;
        end
    end

    // Readout ends a fixed time after exposure starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            frame_done_in <= 1'b0;
        end else begin
            if (expose_start) begin
                cnt <= DONE_LAT;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            frame_done_in <= (cnt == 1);
        end
    end
endmodule : asgate_ext_src

// ==== verification/asgate_top_tb.sv ====
// Self-checking bench of the acquisition start trigger gate
`timescale 1ns/1ps
module asgate_top_tb;
    import asgate_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, line1_in, frame_trig_in, frame_done_in;
    logic frame_expose_start, frame_soft_pulse, legacy_mode;
    asgate_trig_cfg_t frame_cfg;
    logic fire = 1'b0;
    logic line_lvl = 1'b0;
    logic [31:0] seed = 32'h56b9ddf6;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int compares = 0;
    int nf;

    asgate_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line1_in(line1_in), .frame_trig_in(frame_trig_in),
        .frame_done_in(frame_done_in), .frame_expose_start(frame_expose_start),
        .frame_soft_pulse(frame_soft_pulse), .frame_cfg(frame_cfg),
        .legacy_mode(legacy_mode));

    asgate_ext_src src (.pclk(pclk), .presetn(presetn), .fire(fire),
        .line_lvl(line_lvl), .expose_start(frame_expose_start),
        .line1_in(line1_in), .frame_trig_in(frame_trig_in),
        .frame_done_in(frame_done_in));

    // Clock
    always #10 pclk = ~pclk;

    // Next pseudo-random value
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Expected state and count fields of the status word
    function automatic logic [31:0] exp_stat(input logic st,
                                             input logic [7:0] cnt);
        exp_stat = {16'h0, cnt, 7'h0, st};
    endfunction : exp_stat

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; read data and error taken at the ready edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task status(input logic st, input logic [7:0] cnt);
        apb(1'b0, ASG_STATUS_OFS, 32'h0);
        check(rd & 32'hff01, exp_stat(st, cnt));
    endtask : status

    // Fire one frame trigger after a random gap, then let readout end
    task frame(input logic exp);
        logic seen;
        seen = 1'b0;
        seed = lfsr(seed);
        repeat (seed[2:0]) @(posedge pclk);
        @(posedge pclk);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (4) begin
            @(posedge pclk);
            #1;
            if (frame_expose_start === 1'b1) seen = 1'b1;
        end
        repeat (10) @(posedge pclk);
        check({31'h0, seen}, {31'h0, exp});
    endtask : frame

    task report_and_stop;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        report_and_stop;
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check(legacy_mode, 32'h1);
        apb(1'b0, ASG_CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, ASG_FRAMES_OFS, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        check({rd[30:0], err}, 32'h1);
        // Legacy mode: gate enable has no effect
        apb(1'b1, ASG_TRIG_OFS, 32'h1);
        apb(1'b1, ASG_CMD_OFS, 32'h2);
        frame(1'b1);
        // Standard mode, continuous, software start
        apb(1'b1, ASG_CTRL_OFS, 32'h5);
        #1;
        check(legacy_mode, 32'h0);
        seed = lfsr(seed);
        nf = int'(seed[1:0]) + 2;
        apb(1'b1, ASG_FRAMES_OFS, 32'(nf));
        frame(1'b0);
        apb(1'b1, ASG_CMD_OFS, 32'h1);
        status(1'b1, 8'h0);
        frame(1'b1);
        apb(1'b1, ASG_CMD_OFS, 32'h1);
        status(1'b1, 8'h1);
        for (int i = 1; i < nf; i++) frame(1'b1);
        status(1'b0, 8'(nf));
        frame(1'b0);
        apb(1'b1, ASG_CMD_OFS, 32'h1);
        status(1'b1, 8'h0);
        for (int i = 0; i < nf; i++) frame(1'b1);
        status(1'b0, 8'(nf));
        // Line source, both polarities; wrong edge first
        apb(1'b1, ASG_FRAMES_OFS, 32'h1);
        for (int pol = 0; pol < 2; pol++) begin
            @(posedge pclk);
            line_lvl <= (pol == 0);
            apb(1'b1, ASG_TRIG_OFS, {29'h0, pol[0], 2'b11});
            @(posedge pclk);
            line_lvl <= (pol != 0);
            repeat (4) @(posedge pclk);
            status(1'b0, (pol == 0) ? 8'(nf) : 8'h1);
            @(posedge pclk);
            line_lvl <= (pol == 0);
            repeat (4) @(posedge pclk);
            status(1'b1, 8'h0);
            frame(1'b1);
            status(1'b0, 8'h1);
        end
        // Gate off: no outside start needed, state held in start wait
        apb(1'b1, ASG_TRIG_OFS, 32'h0);
        repeat (3) frame(1'b1);
        apb(1'b0, ASG_STATUS_OFS, 32'h0);
        check(rd[0], 32'h0);
        // Selector routes settings and software command
        apb(1'b1, ASG_CTRL_OFS, 32'h7);
        apb(1'b1, ASG_TRIG_OFS, 32'h7);
        #1;
        check(frame_cfg, 32'h7);
        apb(1'b1, ASG_CMD_OFS, 32'h1);
        #1;
        check(frame_soft_pulse, 32'h1);
        apb(1'b1, ASG_CTRL_OFS, 32'h5);
        apb(1'b0, ASG_TRIG_OFS, 32'h0);
        check(rd, 32'h0);
        // Disarm while a frame runs
        @(posedge pclk);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        apb(1'b1, ASG_CMD_OFS, 32'h4);
        repeat (10) @(posedge pclk);
        frame(1'b0);
        apb(1'b0, ASG_STATUS_OFS, 32'h0);
        check(rd[2:1], 32'h0);
        // Gate on with single run style is flagged as host misuse
        apb(1'b1, ASG_CTRL_OFS, 32'h1);
        apb(1'b1, ASG_TRIG_OFS, 32'h1);
        apb(1'b0, ASG_STATUS_OFS, 32'h0);
        check(rd[4:3], 32'h3);
        // Frame count range
        apb(1'b1, ASG_FRAMES_OFS, 32'h0);
        apb(1'b0, ASG_FRAMES_OFS, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, ASG_FRAMES_OFS, 32'hff);
        apb(1'b0, ASG_FRAMES_OFS, 32'h0);
        check(rd, 32'hff);
        report_and_stop;
    end
endmodule : asgate_top_tb
